// *** design/io_space_pkg.sv ***
// Purpose: Shared constants and carriers for the peripheral I/O register bank
// Assumes: Byte-wide register space seen from the processor core
// Notes: Addresses are I/O addresses unless named as data-space addresses
package io_space_pkg;

  // Address windows
  localparam logic [7:0] IO_LIMIT = 8'h3F;       // Last address of the port operations
  localparam logic [7:0] BIT_LIMIT = 8'h1F;      // Last bit-addressable register
  localparam logic [7:0] DATA_IO_OFFSET = 8'h20; // Data address of I/O address zero
  localparam logic [7:0] EXT_FIRST = 8'h60;      // First data address of the extended region

  // Register locations
  localparam int STORE_COUNT = 3;
  localparam logic [5:0] STORE_ADDR [STORE_COUNT] = '{6'h1E, 6'h2A, 6'h2B};
  localparam logic [5:0] FLAGS_ADDR = 6'h1C;     // Write-one-to-clear status flags

  // Values after reset
  localparam logic [7:0] STORE_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Operations issued by the core
  typedef enum logic [2:0] {
    op_none,
    io_read_op,
    io_write_op,
    data_space_load_ops,
    data_space_store_ops,
    set_single_bit_op,
    clear_single_bit_op,
    skip_if_bit_set_op
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } access_t;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [7:0] rdata;
    logic bit_value;
  } answer_t;

endpackage

// *** design/io_space_register_bank.sv ***
// Purpose: Decode and access logic for the peripheral I/O register space
// Assumes: Core accesses arrive on the core clock; flag set pulses come from
//   peripheral logic on the same clock
// Notes: Answer is registered one cycle after the access is taken
// Summary of operation
// - Loads and stores reach every I/O location
// - Addresses 0x00-0x1F take bit set, clear, test
// - Port operations use addresses 0x00-0x3F only
// - Data address equals I/O address plus 0x20
// - Extended 0x60-0xFF only through loads and stores
// - Writing one clears status flags; zero keeps
// - Bit operations touch only the addressed bit
// - Three zero-reset storage registers at 0x1E/0x2A/0x2B
`timescale 1ns/100ps
module io_space_register_bank #(
  parameter int FLAG_WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire io_space_pkg::access_t i_access,
  input wire logic [FLAG_WIDTH-1:0] i_flag_set,
  output io_space_pkg::answer_t o_answer
);
  import io_space_pkg::*;

  if (FLAG_WIDTH < 1 || FLAG_WIDTH > 8) begin : g_width_check
    $error("FLAG_WIDTH must lie between 1 and 8");
  end

  logic rst_meta;
  logic rst_sync;
  logic [7:0] storage [STORE_COUNT];
  logic [FLAG_WIDTH-1:0] flags;
  logic legal;
  logic io_hit;
  logic [5:0] io_idx;
  logic full_write;
  logic [7:0] cur_value;
  logic [7:0] bit_mask;
  logic [FLAG_WIDTH-1:0] flag_clear;
  logic [FLAG_WIDTH-1:0] next_flags;

  // Register value at one I/O index; unmapped indices read zero
  function automatic logic [7:0] reg_value(input logic [5:0] idx,
                                           input logic [7:0] s0,
                                           input logic [7:0] s1,
                                           input logic [7:0] s2,
                                           input logic [FLAG_WIDTH-1:0] fl);
    logic [7:0] v;
    v = READ_ZERO;
    if (idx == STORE_ADDR[0]) v = s0;
    if (idx == STORE_ADDR[1]) v = s1;
    if (idx == STORE_ADDR[2]) v = s2;
    if (idx == FLAGS_ADDR) v = 8'(fl);
    return v;
  endfunction

  // Reset release through two flops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Address decode per operation kind
  always_comb begin
    legal = 1'b0;
    io_hit = 1'b0;
    io_idx = i_access.addr[5:0];
    case (i_access.op)
      io_read_op, io_write_op: begin
        legal = (i_access.addr <= IO_LIMIT);
        io_hit = legal;
      end
      data_space_load_ops, data_space_store_ops: begin
        legal = (i_access.addr >= DATA_IO_OFFSET);
        io_hit = legal && (i_access.addr < EXT_FIRST);
        io_idx = 6'(i_access.addr - DATA_IO_OFFSET);
      end
      set_single_bit_op, clear_single_bit_op, skip_if_bit_set_op: begin
        legal = (i_access.addr <= BIT_LIMIT);
        io_hit = legal;
      end
      default: begin
        legal = 1'b0;
        io_hit = 1'b0;
      end
    endcase
  end

  // Write qualifiers and current value of the addressed register
  assign full_write = io_hit && (i_access.op == io_write_op ||
                                 i_access.op == data_space_store_ops);
  assign cur_value = reg_value(io_idx, storage[0], storage[1], storage[2], flags);
  assign bit_mask = 8'h01 << i_access.bit_sel;

  // Flags cleared by writing ones; single-bit set clears only its own bit
  always_comb begin
    flag_clear = '0;
    if (io_idx == FLAGS_ADDR && full_write) begin
      flag_clear = i_access.wdata[FLAG_WIDTH-1:0];
    end else if (io_idx == FLAGS_ADDR && io_hit && i_access.op == set_single_bit_op) begin
      flag_clear = bit_mask[FLAG_WIDTH-1:0];
    end
    next_flags = (flags & ~flag_clear) | i_flag_set; // Set wins over clear
  end

  // Status flag register
  always_ff @(posedge i_clock or negedge rst_sync) begin
    if (!rst_sync) begin
      flags <= FLAGS_RESET[FLAG_WIDTH-1:0];
    end else if (i_enable) begin
      flags <= next_flags;
    end
  end

  // General purpose storage registers
  for (genvar g = 0; g < STORE_COUNT; g++) begin : g_store
    always_ff @(posedge i_clock or negedge rst_sync) begin
      if (!rst_sync) begin
        storage[g] <= STORE_RESET;
      end else if (i_enable && io_hit && io_idx == STORE_ADDR[g]) begin
        if (full_write) begin
          storage[g] <= i_access.wdata;
        end else if (i_access.op == set_single_bit_op) begin
          storage[g] <= storage[g] | bit_mask;
        end else if (i_access.op == clear_single_bit_op) begin
          storage[g] <= storage[g] & ~bit_mask;
        end
      end
    end
  end

  // Registered answer to the core
  always_ff @(posedge i_clock or negedge rst_sync) begin
    if (!rst_sync) begin
      o_answer <= '0;
    end else if (i_enable) begin
      o_answer.valid <= (i_access.op != op_none);
      o_answer.refused <= (i_access.op != op_none) && !legal;
      o_answer.rdata <= READ_ZERO;
      o_answer.bit_value <= 1'b0;
      if (i_access.op == io_read_op || i_access.op == data_space_load_ops) begin
        o_answer.rdata <= io_hit ? cur_value : READ_ZERO;
      end
      if (i_access.op == skip_if_bit_set_op && io_hit) begin
        o_answer.bit_value <= cur_value[i_access.bit_sel];
      end
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!rst_sync);

  a_port_range_refused: assert property (
    (i_enable && (i_access.op == io_read_op || i_access.op == io_write_op)
     && i_access.addr > 8'h3F) |=> (o_answer.valid && o_answer.refused))
    else $error("port access beyond 0x3F not refused");

  a_bit_range_refused: assert property (
    (i_enable && i_access.op == set_single_bit_op && i_access.addr > 8'h1F)
    |=> o_answer.refused)
    else $error("bit operation beyond 0x1F not refused");

  a_extended_load_zero: assert property (
    (i_enable && i_access.op == data_space_load_ops && i_access.addr >= 8'h60)
    |=> (!o_answer.refused && o_answer.rdata == 8'h00))
    else $error("extended load refused or not zero");

  a_data_alias_store: assert property (
    (i_enable && i_access.op == data_space_store_ops && i_access.addr == 8'h3E)
    |=> storage[0] == $past(i_access.wdata))
    else $error("data address 0x3E did not reach storage zero");

  a_port_write_store: assert property (
    (i_enable && i_access.op == io_write_op && i_access.addr == 8'h2A)
    ##1 (i_enable && i_access.op == io_read_op && i_access.addr == 8'h2A)
    |=> o_answer.rdata == $past(i_access.wdata, 2))
    else $error("storage one did not return written value");

  a_w1c_flags: assert property (
    (i_enable && i_access.op == data_space_store_ops && i_access.addr == 8'h3C
     && i_flag_set == '0) |=> flags == ($past(flags) & ~$past(i_access.wdata[FLAG_WIDTH-1:0])))
    else $error("status flags not cleared by ones");

  a_bit_set_only: assert property (
    (i_enable && i_access.op == set_single_bit_op && i_access.addr == 8'h1E)
    |=> storage[0] == ($past(storage[0]) | (8'h01 << $past(i_access.bit_sel))))
    else $error("bit set disturbed other bits");

  a_bit_set_flags: assert property (
    (i_enable && i_access.op == set_single_bit_op && i_access.addr == 8'h1C
     && i_flag_set == '0) |=> flags == ($past(flags) & ~$past(bit_mask[FLAG_WIDTH-1:0])))
    else $error("bit set on flags cleared other flags");

  a_reserved_read_zero: assert property (
    (i_enable && i_access.op == io_read_op && i_access.addr == 8'h3F)
    |=> (o_answer.rdata == 8'h00 && !o_answer.refused))
    else $error("reserved address read not zero");

  a_bit_test_value: assert property (
    (i_enable && i_access.op == skip_if_bit_set_op && i_access.addr == 8'h1E)
    |=> o_answer.bit_value == $past(storage[0][i_access.bit_sel]))
    else $error("bit test returned wrong value");

  c_store_then_load: cover property (
    (i_access.op == data_space_store_ops) ##1 (i_access.op == data_space_load_ops));
  c_flag_cleared: cover property ((flags != '0) ##1 (flags == '0));
  c_refused: cover property (o_answer.refused);
  c_bit_test_one: cover property (o_answer.bit_value);

endmodule

// *** verif/core_model.sv ***
// Purpose: Core model issuing accesses to the I/O register bank
// Assumes: Requests change at the falling edge
// Notes: Released address and data lines show inverted values
`timescale 1ns/100ps
module core_model (
  input wire logic i_clock,
  input wire io_space_pkg::answer_t i_answer,
  output io_space_pkg::access_t o_access
);
  import io_space_pkg::*;
  // Idle request at time zero
  initial begin
    o_access = '{op: op_none, addr: 8'h00, bit_sel: 3'h0, wdata: 8'h00};
  end
  // Present one access for one edge, then release and take the answer
  task automatic run(input op_t op, input logic [7:0] addr, input logic [2:0] bsel,
    input logic [7:0] wdata, output answer_t ans);
    @(negedge i_clock);
    o_access = '{op: op, addr: addr, bit_sel: bsel, wdata: wdata};
    @(negedge i_clock);
    ans = i_answer;
    o_access = '{op: op_none, addr: ~addr, bit_sel: ~bsel, wdata: ~wdata};
  endtask
  // Port write then port read of one address on back-to-back edges
  task automatic run_pair(input logic [7:0] addr, input logic [7:0] wdata, output answer_t ans);
    @(negedge i_clock);
    o_access = '{op: io_write_op, addr: addr, bit_sel: 3'h0, wdata: wdata};
    @(negedge i_clock);
    o_access = '{op: io_read_op, addr: addr, bit_sel: 3'h0, wdata: 8'h00};
    @(negedge i_clock);
    ans = i_answer;
    o_access = '{op: op_none, addr: ~addr, bit_sel: 3'h7, wdata: ~wdata};
  endtask
endmodule

// *** verif/test_io_space_register_bank.sv ***
// Purpose: Self-checking bench for the I/O register bank
// Assumes: Core model drives the access port
// Notes: Reserved places are only read, never written
`timescale 1ns/100ps
module test_io_space_register_bank;
  import io_space_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_enable = 1'b1;
  logic [7:0] i_flag_set = 8'h00;
  access_t i_access;
  answer_t o_answer;
  answer_t ans;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] a;
  always #10 i_clock = ~i_clock;
  io_space_register_bank #(.FLAG_WIDTH(8)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_enable(i_enable), .i_access(i_access), .i_flag_set(i_flag_set), .o_answer(o_answer));
  core_model core (.i_clock(i_clock), .i_answer(o_answer), .o_access(i_access));
  // Compare bytes and single bits
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  // One access with its answer judged
  task automatic acc(input op_t op, input logic [7:0] ad, input logic [2:0] b,
    input logic [7:0] wd, input logic refd, input logic [7:0] exp);
    core.run(op, ad, b, wd, ans);
    check1(ans.valid, 1'b1);
    check1(ans.refused, refd);
    if (refd || op == io_read_op || op == data_space_load_ops) check8(ans.rdata, exp);
  endtask
  task automatic report_and_stop;
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic t_reset_values;
    for (int i = 0; i < STORE_COUNT; i++) acc(io_read_op, {2'b00, STORE_ADDR[i]}, 0, 0, 0, 0);
    acc(io_read_op, {2'b00, FLAGS_ADDR}, 0, 0, 0, FLAGS_RESET);
  endtask
  task automatic t_storage;
    for (int i = 0; i < STORE_COUNT; i++) begin
      a = {2'b00, STORE_ADDR[i]};
      acc(io_write_op, a, 0, 8'h3C + 8'(i), 0, 0);
      acc(data_space_load_ops, a + DATA_IO_OFFSET, 0, 0, 0, 8'h3C + 8'(i));
      acc(data_space_store_ops, a + 8'h20, 0, ~(8'h3C + 8'(i)), 0, 0);
      acc(io_read_op, a, 0, 0, 0, ~(8'h3C + 8'(i)));
    end
  endtask
  task automatic t_bits;
    acc(io_write_op, 8'h1E, 0, 8'h00, 0, 0);
    acc(set_single_bit_op, 8'h1E, 3, 8'hFF, 0, 0);
    acc(set_single_bit_op, 8'h1E, 7, 8'h00, 0, 0);
    acc(clear_single_bit_op, 8'h1E, 3, 8'hFF, 0, 0);
    acc(io_read_op, 8'h1E, 0, 0, 0, 8'h80);
    acc(skip_if_bit_set_op, 8'h1E, 7, 0, 0, 0);
    check1(ans.bit_value, 1'b1);
    acc(skip_if_bit_set_op, 8'h1E, 0, 0, 0, 0);
    check1(ans.bit_value, 1'b0);
    acc(set_single_bit_op, 8'h2A, 0, 0, 1, 0);
    acc(io_read_op, 8'h2A, 0, 0, 0, 8'hC2);
  endtask
  task automatic t_flags;
    @(negedge i_clock) i_flag_set = 8'hA5;
    @(negedge i_clock) i_flag_set = 8'h00;
    acc(io_read_op, 8'h1C, 0, 0, 0, 8'hA5);
    acc(io_write_op, 8'h1C, 0, 8'h05, 0, 0);
    acc(io_read_op, 8'h1C, 0, 0, 0, 8'hA0);
    acc(set_single_bit_op, 8'h1C, 5, 0, 0, 0);
    acc(clear_single_bit_op, 8'h1C, 7, 0, 0, 0);
    acc(data_space_load_ops, 8'h3C, 0, 0, 0, 8'h80);
    acc(data_space_store_ops, 8'h3C, 0, 8'h80, 0, 0);
    acc(io_read_op, 8'h1C, 0, 0, 0, 8'h00);
  endtask
  task automatic t_enable;
    @(negedge i_clock) i_enable = 1'b0;
    core.run(io_write_op, 8'h2B, 0, 8'h11, ans);
    check1(ans.valid, 1'b0);
    i_enable = 1'b1;
    acc(io_read_op, 8'h2B, 0, 0, 0, 8'hC1);
    core.run_pair(8'h2A, 8'h5A, ans);
    check8(ans.rdata, 8'h5A);
  endtask
  task automatic t_refusals;
    acc(io_read_op, 8'h40, 0, 0, 1, 0);
    acc(io_write_op, 8'h6B, 0, 8'hFF, 1, 0);
    acc(io_read_op, 8'h2B, 0, 0, 0, 8'hC1);
    acc(data_space_load_ops, 8'h1E, 0, 0, 1, 0);
    acc(data_space_load_ops, 8'h80, 0, 0, 0, 0);
    acc(io_read_op, 8'h10, 0, 0, 0, 0);
    acc(io_read_op, 8'h3F, 0, 0, 0, 0);
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (12) @(posedge i_clock);
    @(negedge i_clock) i_rst_n = 1'b1;
    repeat (3) @(posedge i_clock);
    t_reset_values();
    t_storage();
    t_bits();
    t_flags();
    t_refusals();
    t_enable();
    report_and_stop();
  end
endmodule
